// ===== rtl/cdp_cfg.svh
`ifndef CDP_CFG_SVH
`define CDP_CFG_SVH
// ****************************************
// Clock and link timing
// ****************************************
`define CDP_CLK_MHZ 20
`define CDP_T_CONV_NS 22
`define CDP_T_S1_NS 9
`define CDP_SCK_MAX_MHZ 40
// Least times round up to whole cycles
`define CDP_CONV_CYC ((`CDP_T_CONV_NS * `CDP_CLK_MHZ + 999) / 1000)
`define CDP_S1_CYC ((`CDP_T_S1_NS * `CDP_CLK_MHZ + 999) / 1000)
`define CDP_PIX_DIV 4
`define CDP_PIPE_CYCLES 15
`define CDP_CLAMP_MIN 2
`define CDP_CLAMP_REC 20
// ****************************************
// Serial word and device registers
// ****************************************
`define CDP_SER_BITS 16
`define CDP_SER_ADDR_LSB 12
`define CDP_SER_ADDR_W 4
`define CDP_SER_DATA_W 10
`define CDP_REG_VGA 4'h0
`define CDP_REG_CLAMP 4'h1
`define CDP_REG_CDS 4'h2
`define CDP_REG_CTRL 4'h3
`define CDP_VGA_RST 10'h00F
`define CDP_VGA_MIN 10'h00F
`define CDP_CLAMP_RST 10'h000
`define CDP_CTRL_POL_BIT 0
// ****************************************
// Controller registers on Avalon-MM
// ****************************************
`define CDP_AV_CTRL 4'h0
`define CDP_AV_SER 4'h4
`define CDP_AV_STATUS 4'h8
`define CDP_AV_CLAMP 4'hC
`define CDP_AV_BLANK_BIT 0
`define CDP_AV_BUSY_BIT 0
`define CDP_AV_CLPACT_BIT 1
`endif

// ===== rtl/cdp_dev.sv
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "cdp_cfg.svh"
// How it works
// - Reference on ref clock, data on data clock
// - Pixel word out 15 latch clocks later
// - Preblanked pixels come out as zero
// - Clamp window overrides preblank
// - Generator holds clamp at least 2 pixels
// - Windows aligned to input pixel, not output
// - Unused preblank held inactive
// - 10-bit monotonic gain, minimum at code 15
// - Clamp code sets black level linearly
// - Gain code 15, CDS 0 dB after reset
// - Clock periods no shorter than 22 ns
// - Ref edge leads data edge half a pixel, 9 ns at least
// - Serial clock not above pixel rate
// - Serial data captured on clock rise
// - Latch edge near a sample edge
// - Pixel outputs update on output latch clock
// - Load pulse transfers shifted serial word

module cdp_dev
	import cdp_pkg::*;
#(
	parameter int PIPE_CYCLES = `CDP_PIPE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] ccd_level,
	output logic [9:0] vga_code,
	output logic [9:0] clamp_code,
	output logic [1:0] cds_sel,
	output logic sample_pol,
	cdp_link_if.dev link
);
	// out_ff is the last stage, so the shift chain holds one fewer
	localparam int DEPTH = PIPE_CYCLES - 1;

	// ****************************************
	// Conversion arithmetic
	// ****************************************
	// Digital stand-in for the analog chain; monotonic in the code
	function automatic logic [23:0] cdp_vga(input logic [11:0] d, input logic [9:0] code);
		logic [9:0] c;
		c = (code < `CDP_VGA_MIN) ? `CDP_VGA_MIN : code;
		return (24'(d) * 24'(c)) >> 3;
	endfunction : cdp_vga

	// CDS step as a quarter-unit multiplier: -3, 0, +3, +6 dB
	function automatic logic [3:0] cdp_cds_mul(input logic [1:0] sel);
		unique case (cdp_cds_t'(sel))
			CDP_CDS_0DB: return 4'h4;
			CDP_CDS_M3DB: return 4'h3;
			CDP_CDS_P3DB: return 4'h6;
			CDP_CDS_P6DB: return 4'h8;
		endcase
	endfunction : cdp_cds_mul

	// Saturate rather than wrap, so bright pixels stay at full scale
	function automatic logic [11:0] cdp_sat(input logic [27:0] v);
		return (v > 28'h0000FFF) ? 12'hFFF : v[11:0];
	endfunction : cdp_sat
	// Edge seen one clock late; every pin comes from a far-end flop, so no sync stage
	function automatic logic cdp_rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction : cdp_rise

	// ****************************************
	// Pin edge detection
	// ****************************************
	logic ref_prev_ff, data_prev_ff, latch_prev_ff, sck_prev_ff, load_prev_ff;
	logic [11:0] ref_lvl_ff, black_ff;
	cdp_word_t word_ff;
	logic blank_pix_ff;
	cdp_word_t pipe_word_ff [DEPTH];
	logic pipe_blank_ff [DEPTH];
	cdp_word_t out_ff;
	logic [`CDP_SER_BITS-1:0] ser_sh_ff;
	logic [9:0] vga_ff, clamp_lvl_ff;
	logic [1:0] cds_ff;
	logic pol_ff;

	// Polarity bit picks the active edge of both sample clocks
	wire ref_edge = pol_ff ? cdp_rise(ref_prev_ff, link.ref_sample_clk) :
		cdp_rise(link.ref_sample_clk, ref_prev_ff);
	wire data_edge = pol_ff ? cdp_rise(data_prev_ff, link.data_sample_clk) :
		cdp_rise(link.data_sample_clk, data_prev_ff);
	wire latch_edge = cdp_rise(link.output_latch_clk, latch_prev_ff);
	wire sck_rise = cdp_rise(link.serial_clk, sck_prev_ff);
	wire load_rise = cdp_rise(link.serial_load_pulse, load_prev_ff);

	// Previous pin levels; reset to the idle low level so no false edge follows reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_prev_ff <= 1'b0;
			data_prev_ff <= 1'b0;
			latch_prev_ff <= 1'b0;
			sck_prev_ff <= 1'b0;
			load_prev_ff <= 1'b0;
		end else begin
			ref_prev_ff <= link.ref_sample_clk;
			data_prev_ff <= link.data_sample_clk;
			latch_prev_ff <= link.output_latch_clk;
			sck_prev_ff <= link.serial_clk;
			load_prev_ff <= link.serial_load_pulse;
		end
	end

	// ****************************************
	// Correlated double sampling and clamp
	// ****************************************
	// Swing taken as data less reference; a negative swing floors at zero
	wire [11:0] cds_diff = (ccd_level < ref_lvl_ff) ? 12'h000 : ccd_level - ref_lvl_ff;
	wire [11:0] net_diff = (cds_diff < black_ff) ? 12'h000 : cds_diff - black_ff;
	wire [27:0] gained = (28'(cdp_vga(net_diff, vga_ff)) * 28'(cdp_cds_mul(cds_ff))) >> 2;
	// Clamp code 0..1023 maps to 0..511 LSB of black level
	wire [11:0] black_lsb = {3'h0, clamp_lvl_ff[9:1]};
	wire [12:0] word_sum = 13'(cdp_sat(gained)) + 13'(black_lsb);
	wire [11:0] nxt_word = word_sum[12] ? 12'hFFF : word_sum[11:0];
	// Running average keeps the black estimate quiet; short windows settle less
	wire [12:0] nxt_black = (cds_diff > black_ff) ? 13'(black_ff) + 13'((cds_diff - black_ff) >> 3) :
		13'(black_ff) - 13'((black_ff - cds_diff) >> 3);

	// Window levels are taken with the pixel's own data sample, not at the output
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_lvl_ff <= 12'h000;
			black_ff <= 12'h000;
			word_ff <= 12'h000;
			blank_pix_ff <= 1'b0;
		end else begin
			if (ref_edge)
				ref_lvl_ff <= ccd_level;
			if (data_edge) begin
				word_ff <= nxt_word;
				blank_pix_ff <= link.preblank_in & ~link.black_clamp_window;
				if (link.black_clamp_window)
					black_ff <= nxt_black[11:0];
			end
		end
	end

	// ****************************************
	// Output pipeline on the latch clock
	// ****************************************
	// Blank flag travels with its pixel, so zeroing lands on the right output word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				pipe_word_ff[i] <= 12'h000;
				pipe_blank_ff[i] <= 1'b0;
			end
			out_ff <= 12'h000;
		end else if (latch_edge) begin
			pipe_word_ff[0] <= word_ff;
			pipe_blank_ff[0] <= blank_pix_ff;
			for (int i = 1; i < DEPTH; i++) begin
				pipe_word_ff[i] <= pipe_word_ff[i-1];
				pipe_blank_ff[i] <= pipe_blank_ff[i-1];
			end
			out_ff <= pipe_blank_ff[DEPTH-1] ? 12'h000 : pipe_word_ff[DEPTH-1];
		end
	end

	// ****************************************
	// Serial register port
	// ****************************************
	wire [3:0] ser_addr = ser_sh_ff[`CDP_SER_ADDR_LSB +: `CDP_SER_ADDR_W];
	wire [9:0] ser_data = ser_sh_ff[`CDP_SER_DATA_W-1:0];
	// One strobe per register; the word lands only on the load edge
	wire wr_vga = load_rise & (ser_addr == `CDP_REG_VGA);
	wire wr_clamp = load_rise & (ser_addr == `CDP_REG_CLAMP);
	wire wr_cds = load_rise & (ser_addr == `CDP_REG_CDS);
	wire wr_ctrl = load_rise & (ser_addr == `CDP_REG_CTRL);

	// Shift in MSB first on each serial clock rise
	always_ff @(posedge clk) begin
		if (!rst_n)
			ser_sh_ff <= '0;
		else if (sck_rise)
			ser_sh_ff <= {ser_sh_ff[`CDP_SER_BITS-2:0], link.serial_din};
	end

	// Transfer on load; unknown addresses are dropped so stray words do no harm
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vga_ff <= `CDP_VGA_RST;
			clamp_lvl_ff <= `CDP_CLAMP_RST;
			cds_ff <= CDP_CDS_0DB;
			pol_ff <= 1'b0;
		end else begin
			if (wr_vga)
				vga_ff <= ser_data;
			if (wr_clamp)
				clamp_lvl_ff <= ser_data;
			if (wr_cds)
				cds_ff <= ser_data[1:0];
			if (wr_ctrl)
				pol_ff <= ser_data[`CDP_CTRL_POL_BIT];
		end
	end

	// Every output straight from its register
	assign link.pixel_data = out_ff;
	assign vga_code = vga_ff;
	assign clamp_code = clamp_lvl_ff;
	assign cds_sel = cds_ff;
	assign sample_pol = pol_ff;
endmodule : cdp_dev

// ===== rtl/cdp_link_if.sv
`timescale 1ns/10ps
interface cdp_link_if;
	logic ref_sample_clk;
	logic data_sample_clk;
	logic output_latch_clk;
	logic black_clamp_window;
	logic preblank_in;
	logic serial_clk;
	logic serial_din;
	logic serial_load_pulse;
	logic [11:0] pixel_data;
	// Converter end
	modport dev (
		input ref_sample_clk, data_sample_clk, output_latch_clk, black_clamp_window,
		input preblank_in, serial_clk, serial_din, serial_load_pulse,
		output pixel_data
	);
	// Timing generator and serial host end
	modport tgen (
		output ref_sample_clk, data_sample_clk, output_latch_clk, black_clamp_window,
		output preblank_in, serial_clk, serial_din, serial_load_pulse,
		input pixel_data
	);
endinterface : cdp_link_if

// ===== rtl/cdp_pkg.sv
package cdp_pkg;
	// CDS gain choices; nominal 0 dB after reset
	typedef enum logic [1:0] {
		CDP_CDS_0DB = 2'h0,
		CDP_CDS_M3DB = 2'h1,
		CDP_CDS_P3DB = 2'h2,
		CDP_CDS_P6DB = 2'h3
	} cdp_cds_t;
	// Serial writer states
	typedef enum logic [2:0] {
		CDP_SER_IDLE = 3'b001,
		CDP_SER_SHIFT = 3'b010,
		CDP_SER_LOAD = 3'b100
	} cdp_ser_state_t;
	typedef logic [11:0] cdp_word_t;
endpackage : cdp_pkg

// ===== rtl/cdp_tgen.sv
`timescale 1ns/10ps
`include "cdp_cfg.svh"
module cdp_tgen
	import cdp_pkg::*;
#(
	parameter int PIX_DIV = `CDP_PIX_DIV,
	parameter int SCK_HALF = `CDP_PIX_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	cdp_link_if.tgen link
);
	localparam int HALF = (PIX_DIV / 2 < `CDP_S1_CYC) ? `CDP_S1_CYC : PIX_DIV / 2;
	localparam int CW = $clog2(PIX_DIV + SCK_HALF + 1);
	// ****************************************
	// Pixel phase counter and sample clocks
	// ****************************************
	logic [CW-1:0] pix_cnt_ff;
	logic [CW-1:0] sck_cnt_ff;
	logic ref_ff, data_ff, latch_ff;
	logic clamp_ff, blank_ff, blank_req_ff;
	logic [7:0] clamp_left_ff, clamp_pend_ff;
	logic sck_ff, sdin_ff, load_ff;
	logic [`CDP_SER_BITS-1:0] ser_sh_ff;
	logic [4:0] bit_cnt_ff;
	cdp_ser_state_t state_ff;
	logic [31:0] rdata_ff;
	logic wait_ff;
	wire pix_last = (pix_cnt_ff == CW'(PIX_DIV - 1));
	wire ser_busy = (state_ff != CDP_SER_IDLE);
	wire [7:0] clamp_req = (avs_writedata[7:0] < 8'(`CDP_CLAMP_MIN)) ? 8'(`CDP_CLAMP_MIN) : avs_writedata[7:0];
	wire acc = (avs_read | avs_write) & wait_ff;
	wire stall = avs_write & (avs_address == `CDP_AV_SER) & ser_busy;
	wire wr_now = avs_write & ~wait_ff;
	wire sck_tick = (sck_cnt_ff == CW'(SCK_HALF - 1));
	wire [31:0] rd_mux = (avs_address == `CDP_AV_CTRL) ? {31'h0, blank_req_ff} :
		(avs_address == `CDP_AV_STATUS) ? {30'h0, clamp_ff, ser_busy} :
		(avs_address == `CDP_AV_CLAMP) ? {24'h0, clamp_left_ff} : 32'h0;
	// Ref edge at phase 0, data and latch edges together half a pixel later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pix_cnt_ff <= '0;
			ref_ff <= 1'b0;
			data_ff <= 1'b0;
			latch_ff <= 1'b0;
		end else begin
			pix_cnt_ff <= pix_last ? '0 : pix_cnt_ff + 1'b1;
			ref_ff <= pix_last;
			data_ff <= (pix_cnt_ff == CW'(HALF - 1));
			latch_ff <= (pix_cnt_ff == CW'(HALF - 1));
		end
	end
	// Windows change only at a pixel boundary, so they line up with the input pixel
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clamp_ff <= 1'b0;
			blank_ff <= 1'b0;
			clamp_left_ff <= 8'h00;
		end else if (pix_last) begin
			blank_ff <= blank_req_ff;
			clamp_ff <= (clamp_left_ff != 8'h00) | (clamp_pend_ff != 8'h00);
			clamp_left_ff <= (clamp_pend_ff != 8'h00) ? clamp_pend_ff - 8'h01 :
				(clamp_left_ff != 8'h00) ? clamp_left_ff - 8'h01 : 8'h00;
		end
	end
	// ****************************************
	// Avalon-MM slave, one wait state; serial writes stall further while the writer is busy
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
			blank_req_ff <= 1'b0;
			clamp_pend_ff <= 8'h00;
		end else begin
			wait_ff <= ~(acc & ~stall);
			if (acc & ~stall)
				rdata_ff <= rd_mux;
			if (wr_now & (avs_address == `CDP_AV_CTRL))
				blank_req_ff <= avs_writedata[`CDP_AV_BLANK_BIT];
			if (wr_now & (avs_address == `CDP_AV_CLAMP))
				clamp_pend_ff <= clamp_req;
			else if (pix_last)
				clamp_pend_ff <= 8'h00;
		end
	end
	// ****************************************
	// Serial writer
	// ****************************************
	// Data moves on the falling clock so it is stable around the rise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= CDP_SER_IDLE;
			sck_cnt_ff <= '0;
			sck_ff <= 1'b0;
			sdin_ff <= 1'b0;
			load_ff <= 1'b0;
			ser_sh_ff <= '0;
			bit_cnt_ff <= 5'h00;
		end else begin
			sck_cnt_ff <= (sck_tick | ~ser_busy) ? '0 : sck_cnt_ff + 1'b1;
			unique case (state_ff)
				CDP_SER_IDLE: begin
					load_ff <= 1'b0;
					if (wr_now & (avs_address == `CDP_AV_SER)) begin
						ser_sh_ff <= avs_writedata[`CDP_SER_BITS-1:0];
						sdin_ff <= avs_writedata[`CDP_SER_BITS-1];
						bit_cnt_ff <= 5'(`CDP_SER_BITS);
						state_ff <= CDP_SER_SHIFT;
					end
				end
				CDP_SER_SHIFT: begin
					if (sck_tick) begin
						sck_ff <= ~sck_ff;
						if (sck_ff) begin
							ser_sh_ff <= {ser_sh_ff[`CDP_SER_BITS-2:0], 1'b0};
							sdin_ff <= ser_sh_ff[`CDP_SER_BITS-2];
							bit_cnt_ff <= bit_cnt_ff - 5'h01;
							if (bit_cnt_ff == 5'h01)
								state_ff <= CDP_SER_LOAD;
						end
					end
				end
				CDP_SER_LOAD: begin
					if (sck_tick) begin
						load_ff <= ~load_ff;
						if (load_ff)
							state_ff <= CDP_SER_IDLE;
					end
				end
			endcase
		end
	end
	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign link.ref_sample_clk = ref_ff;
	assign link.data_sample_clk = data_ff;
	assign link.output_latch_clk = latch_ff;
	assign link.black_clamp_window = clamp_ff;
	assign link.preblank_in = blank_ff;
	assign link.serial_clk = sck_ff;
	assign link.serial_din = sdin_ff;
	assign link.serial_load_pulse = load_ff;
endmodule : cdp_tgen

// ===== verification/ccd_sample_clamp_output_timing_test.sv
`timescale 1ns/10ps
`include "cdp_cfg.svh"
module ccd_sample_clamp_output_timing_test;
	// ****************************************
	// Bench
	// ****************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [11:0] ccd_level = 12'h000;
	logic [9:0] vga_code;
	logic [9:0] clamp_code;
	logic [1:0] cds_sel;
	logic sample_pol;
	logic [31:0] seed = 32'hC385;
	logic [31:0] rd;
	logic [31:0] v;
	logic [9:0] gcode;
	logic checking = 1'b0;
	logic exp_blank;
	logic flag_q[$];
	int mismatches = 0;
	int total_checks = 0;
	cdp_link_if link ();
	cdp_tgen #(.PIX_DIV(4), .SCK_HALF(2)) u_cdp_tgen (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
	cdp_dev #(.PIPE_CYCLES(15)) u_cdp_dev (.clk(clk), .rst_n(rst_n), .ccd_level(ccd_level), .vga_code(vga_code),
		.clamp_code(clamp_code), .cds_sel(cds_sel), .sample_pol(sample_pol), .link(link));
	cdp_link_assertions #(.PIX_DIV(4)) u_checker (.clk(clk), .rst_n(rst_n), .ref_sample_clk(link.ref_sample_clk),
		.data_sample_clk(link.data_sample_clk), .output_latch_clk(link.output_latch_clk),
		.black_clamp_window(link.black_clamp_window), .preblank_in(link.preblank_in),
		.serial_clk(link.serial_clk), .serial_din(link.serial_din),
		.serial_load_pulse(link.serial_load_pulse), .pixel_data(link.pixel_data));
	initial begin
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// One Avalon access; waits for waitrequest low, bounded
	task av(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 2000);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask : av
	// Serial register write, then wait for the writer to go idle
	task ser(input logic [3:0] a, input logic [9:0] d);
		int n;
		av(1'b1, `CDP_AV_SER, {16'h0000, a, 2'h0, d});
		n = 0;
		do begin
			av(1'b0, `CDP_AV_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		repeat (2) @(posedge clk);
	endtask : ser
	// Random level every clock so reference and data samples differ
	always @(posedge clk) begin
		v = xs();
		ccd_level <= {4'h0, v[7:0]};
	end
	// Model: blank flag per pixel, seen at the output 15 latch clocks on
	always @(posedge clk) begin
		if (rst_n && link.output_latch_clk === 1'b1) begin
			flag_q.push_back(link.preblank_in & ~link.black_clamp_window);
			if (flag_q.size() > 15) begin
				exp_blank = flag_q.pop_front();
				@(negedge clk);
				if (checking) begin
					cmp({31'h0, link.pixel_data === 12'h000}, {31'h0, exp_blank});
				end
			end
		end
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#(50 * 30000);
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cmp({22'h0, vga_code}, 32'h0000000F);
		cmp({22'h0, clamp_code}, 32'h0);
		cmp({30'h0, cds_sel}, 32'h0);
		cmp({31'h0, sample_pol}, 32'h0);
		// High black level keeps unblanked words away from zero
		ser(`CDP_REG_CLAMP, 10'h3FF);
		cmp({22'h0, clamp_code}, 32'h000003FF);
		repeat (80) @(posedge clk);
		checking = 1'b1;
		av(1'b1, `CDP_AV_CTRL, 32'h1);
		av(1'b0, `CDP_AV_CTRL, 32'h0);
		cmp(rd, 32'h00000001);
		repeat (100) @(posedge clk);
		av(1'b1, `CDP_AV_CLAMP, 32'd30);
		repeat (20) @(posedge clk);
		// Thirty-pixel window still open, serial writer idle
		av(1'b0, `CDP_AV_STATUS, 32'h0);
		cmp(rd, 32'h00000002);
		repeat (180) @(posedge clk);
		av(1'b1, `CDP_AV_CLAMP, 32'd1);
		repeat (100) @(posedge clk);
		av(1'b0, `CDP_AV_STATUS, 32'h0);
		cmp(rd, 32'h00000000);
		av(1'b1, `CDP_AV_CTRL, 32'h0);
		repeat (100) @(posedge clk);
		checking = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			ser(`CDP_REG_CDS, 10'(i));
			cmp({30'h0, cds_sel}, 32'(i));
		end
		// Falling-edge sampling mode set, then back to default
		ser(`CDP_REG_CTRL, 10'h001);
		cmp({31'h0, sample_pol}, 32'h00000001);
		ser(`CDP_REG_CTRL, 10'h000);
		cmp({31'h0, sample_pol}, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			v = xs();
			gcode = (i == 3) ? 10'h3FF : v[9:0] | 10'h010;
			ser(`CDP_REG_VGA, gcode);
			cmp({22'h0, vga_code}, {22'h0, gcode});
		end
		av(1'b0, 4'h2, 32'h0);
		cmp(rd, 32'h0);
		report_and_stop();
	end
endmodule : ccd_sample_clamp_output_timing_test

// ===== verification/cdp_link_assertions.sv
`timescale 1ns/10ps
module cdp_link_assertions #(
	parameter int PIX_DIV = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_sample_clk,
	input wire logic data_sample_clk,
	input wire logic output_latch_clk,
	input wire logic black_clamp_window,
	input wire logic preblank_in,
	input wire logic serial_clk,
	input wire logic serial_din,
	input wire logic serial_load_pulse,
	input wire logic [11:0] pixel_data
);
	// ****************************************
	// Link checks
	// ****************************************
	// Clamp length in clocks; saturates so long windows never wrap
	logic [7:0] clamp_cnt_ff;
	always_ff @(posedge clk) begin
		if (!rst_n || !black_clamp_window) begin
			clamp_cnt_ff <= 8'h00;
		end else if (clamp_cnt_ff != 8'hFF) begin
			clamp_cnt_ff <= clamp_cnt_ff + 8'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_REF_TO_DATA: assert property (ref_sample_clk |-> ##2 data_sample_clk)
		else $error("data edge not two clocks after ref edge");
	AST_REF_GAP: assert property (ref_sample_clk |=> !ref_sample_clk [*3])
		else $error("sample clock period too short");
	AST_LATCH_WITH_DATA: assert property (data_sample_clk |-> output_latch_clk)
		else $error("latch edge away from data edge");
	AST_OUT_ON_LATCH: assert property (!$stable(pixel_data) |-> $past(output_latch_clk))
		else $error("output changed without latch clock");
	AST_DIN_STABLE: assert property ($rose(serial_clk) |-> $stable(serial_din))
		else $error("serial data moved at clock rise");
	AST_SCK_HALF: assert property ($rose(serial_clk) |=> serial_clk)
		else $error("serial clock faster than pixel rate");
	AST_LOAD_FRAME: assert property ($rose(serial_load_pulse) |-> !serial_clk ##1 serial_load_pulse)
		else $error("load pulse badly framed");
	AST_CLAMP_MIN: assert property ($fell(black_clamp_window) |-> clamp_cnt_ff >= 8'(2 * PIX_DIV))
		else $error("clamp window under two pixels");
	// Windows move at the edge that raises ref, so both are seen at the same sample
	AST_WIN_ALIGN: assert property (($changed(black_clamp_window) || $changed(preblank_in)) |-> ref_sample_clk)
		else $error("window edge off pixel boundary");
	// Main scenarios reached
	cover property (ref_sample_clk && black_clamp_window && preblank_in);
	cover property ($rose(serial_load_pulse));
	cover property ($fell(black_clamp_window));
endmodule : cdp_link_assertions
